//--- hw/pnc_pkg.sv
package pnc_pkg;

    // command codes of the two setting words
    localparam logic [7:0]  PNC_CMD_DELAY     = 8'hDD;
    localparam logic [7:0]  PNC_CMD_CONFIG    = 8'hDE;

    // values after reset
    localparam logic [15:0] PNC_DELAY_RESET   = 16'h1010;
    localparam logic [15:0] PNC_CONFIG_RESET  = 16'h8888;

    // field positions
    localparam int          PNC_EDGE_WIDTH    = 8;
    localparam int          PNC_FREEZE_BIT    = 7;
    localparam int          PNC_MIN_MSB       = 6;

    // edge index inside each word
    localparam int          PNC_EDGE_LH       = 0;
    localparam int          PNC_EDGE_HL       = 1;

    // interval limits and adaptive step, in ns
    localparam int          PNC_MIN_NS        = -15;
    localparam int          PNC_MAX_NS        = 60;
    localparam int          PNC_STEP_NS       = 2;

    // timing of the drive path
    localparam int          PNC_CLK_PERIOD_NS = 10;
    localparam int          PNC_BASE_TAP      = (-PNC_MIN_NS + PNC_CLK_PERIOD_NS - 1)
                                                / PNC_CLK_PERIOD_NS;
    localparam int          PNC_HIST_DEPTH    = 16;

endpackage : pnc_pkg

//--- hw/pnc_tap_line.sv
`timescale 1ns/1ps
`default_nettype none

// history of the raw pwm command, one bit per clock
module pnc_tap_line
    import pnc_pkg::*;
(
    input  wire logic                      clk_i,
    input  wire logic                      sys_rst_i,
    input  wire logic                      pwm_i,
    output logic [PNC_HIST_DEPTH-1:0]      hist_o
);

    logic [PNC_HIST_DEPTH-1:0] hist_ff;

    // shift in newest sample at bit 0
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            hist_ff <= '0;
        end else begin
            hist_ff <= {hist_ff[PNC_HIST_DEPTH-2:0], pwm_i};
        end
    end

    assign hist_o = hist_ff;

endmodule : pnc_tap_line

`default_nettype wire

//--- hw/pnc_top.sv
`timescale 1ns/1ps
`default_nettype none

// non-overlap control between high-side and low-side gate drives
module pnc_top
    import pnc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        cmd_wr_i,
    input  wire logic        cmd_rd_i,
    input  wire logic [7:0]  cmd_code_i,
    input  wire logic [15:0] cmd_wdata_i,
    output logic      [15:0] cmd_rdata_o,
    output logic             cmd_rvalid_o,
    input  wire logic        pwm_i,
    input  wire logic [1:0]  adapt_up_i,
    input  wire logic [1:0]  adapt_dn_i,
    output logic             drv_high_o,
    output logic             drv_low_o,
    output logic      [15:0] applied_o
);

    logic [15:0]               delay_ff;
    logic [15:0]               config_ff;
    logic [15:0]               max_ff;
    logic [15:0]               applied_ff;
    logic                      last_delay_ff;
    logic [15:0]               rdata_ff;
    logic                      rvalid_ff;
    logic                      drv_high_ff;
    logic                      drv_low_ff;
    logic [PNC_HIST_DEPTH-1:0] hist;
    logic [3:0]                tap_hl;
    logic [3:0]                tap_lh;
    logic                      nxt_drv_high;
    logic                      nxt_drv_low;
    logic                      wr_delay;
    logic                      wr_config;

    localparam logic [3:0]        BASE_TAP = 4'(PNC_BASE_TAP);
    localparam logic signed [8:0] LIM_LO   = 9'(PNC_MIN_NS);
    localparam logic signed [8:0] LIM_HI   = 9'(PNC_MAX_NS);
    localparam logic signed [8:0] STEP     = 9'(PNC_STEP_NS);
    localparam logic [7:0]        TAP_OFS  = 8'(PNC_CLK_PERIOD_NS * PNC_BASE_TAP);
    localparam logic [7:0]        TAP_RND  = 8'(PNC_CLK_PERIOD_NS - 1);
    localparam logic [7:0]        TAP_DIV  = 8'(PNC_CLK_PERIOD_NS);

    // signed ns to a history tap; base tap stands for zero ns
    function automatic logic [3:0] ns_to_tap(input logic signed [7:0] ns);
        logic signed [8:0] c;
        logic [7:0]        s;
        c = 9'(ns);
        if (c < LIM_LO) begin
            c = LIM_LO;
        end else if (c > LIM_HI) begin
            c = LIM_HI;
        end
        s = 8'(c) + TAP_OFS;
        ns_to_tap = 4'((s + TAP_RND) / TAP_DIV); // least time rounds up
    endfunction : ns_to_tap

    assign wr_delay  = cmd_wr_i && (cmd_code_i == PNC_CMD_DELAY);
    assign wr_config = cmd_wr_i && (cmd_code_i == PNC_CMD_CONFIG);

    // delay setting word
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            delay_ff <= PNC_DELAY_RESET;
        end else if (wr_delay) begin
            delay_ff <= cmd_wdata_i;
        end
    end

    // adaptive configuration word
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            config_ff <= PNC_CONFIG_RESET;
        end else if (wr_config) begin
            config_ff <= cmd_wdata_i;
        end
    end

    // remembers whether the previous command write was the delay word
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            last_delay_ff <= 1'b0;
        end else if (cmd_wr_i) begin
            last_delay_ff <= wr_delay;
        end
    end

    // adaptive maxima only move on a delay-then-config pair
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            max_ff <= PNC_DELAY_RESET;
        end else if (wr_config && last_delay_ff) begin
            max_ff <= delay_ff;
        end
    end

    // per-edge applied interval
    for (genvar g = 0; g < 2; g++) begin : g_edge
        logic signed [7:0] setting;
        logic              frozen;
        logic signed [8:0] lo_bound;
        logic signed [8:0] hi_bound;
        logic signed [8:0] cur;
        logic signed [8:0] cand;

        assign setting  = delay_ff[g*PNC_EDGE_WIDTH +: PNC_EDGE_WIDTH];
        assign frozen   = config_ff[g*PNC_EDGE_WIDTH + PNC_FREEZE_BIT];
        // minimum field is ns with 2 ns resolution, low bit ignored
        assign lo_bound = {2'b00, config_ff[g*PNC_EDGE_WIDTH + 1 +: PNC_MIN_MSB],
                           1'b0};
        assign hi_bound = 9'(signed'(max_ff[g*PNC_EDGE_WIDTH +: PNC_EDGE_WIDTH]));
        assign cur      = 9'(signed'(applied_ff[g*PNC_EDGE_WIDTH +: PNC_EDGE_WIDTH]));

        // one step per strobe; nine bits keep the sum from wrapping
        always_comb begin
            cand = cur;
            if (adapt_up_i[g] && !adapt_dn_i[g]) begin
                cand = cur + STEP;
            end else if (adapt_dn_i[g] && !adapt_up_i[g]) begin
                cand = cur - STEP;
            end
            // upper bound wins if software sets minimum above maximum
            if (cand < lo_bound) begin
                cand = lo_bound;
            end
            if (cand > hi_bound) begin
                cand = hi_bound;
            end
        end

        always_ff @(posedge clk_i) begin
            if (sys_rst_i) begin
                applied_ff[g*PNC_EDGE_WIDTH +: PNC_EDGE_WIDTH] <=
                    PNC_DELAY_RESET[g*PNC_EDGE_WIDTH +: PNC_EDGE_WIDTH];
            end else if (frozen) begin
                applied_ff[g*PNC_EDGE_WIDTH +: PNC_EDGE_WIDTH] <= setting;
            end else begin
                applied_ff[g*PNC_EDGE_WIDTH +: PNC_EDGE_WIDTH] <= 8'(cand);
            end
        end
    end

    // raw pwm history
    pnc_tap_line u_tap_line (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pwm_i     (pwm_i),
        .hist_o    (hist)
    );

    assign tap_hl = ns_to_tap(signed'(applied_ff[PNC_EDGE_HL*PNC_EDGE_WIDTH +: PNC_EDGE_WIDTH]));
    assign tap_lh = ns_to_tap(signed'(applied_ff[PNC_EDGE_LH*PNC_EDGE_WIDTH +: PNC_EDGE_WIDTH]));

    // turn-off edges sit at the base tap; turn-on moves later for a gap,
    // earlier for an overlap; pulses shorter than the taps are not preserved
    always_comb begin
        if (tap_lh >= BASE_TAP) begin
            nxt_drv_high = hist[tap_lh] & hist[BASE_TAP];
        end else begin
            nxt_drv_high = hist[tap_lh] | hist[BASE_TAP];
        end
        if (tap_hl >= BASE_TAP) begin
            nxt_drv_low = ~hist[tap_hl] & ~hist[BASE_TAP];
        end else begin
            nxt_drv_low = ~hist[tap_hl] | ~hist[BASE_TAP];
        end
    end

    // drives registered so the gate pins never glitch
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            drv_high_ff <= 1'b0;
            drv_low_ff  <= 1'b0;
        end else begin
            drv_high_ff <= nxt_drv_high;
            drv_low_ff  <= nxt_drv_low;
        end
    end

    // read answer one cycle after the request, zero for unknown codes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rdata_ff  <= '0;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= cmd_rd_i;
            if (!cmd_rd_i) begin
                rdata_ff <= rdata_ff;
            end else if (cmd_code_i == PNC_CMD_DELAY) begin
                rdata_ff <= delay_ff;
            end else if (cmd_code_i == PNC_CMD_CONFIG) begin
                rdata_ff <= config_ff;
            end else begin
                rdata_ff <= '0;
            end
        end
    end

    assign cmd_rdata_o  = rdata_ff;
    assign cmd_rvalid_o = rvalid_ff;
    assign drv_high_o   = drv_high_ff;
    assign drv_low_o    = drv_low_ff;
    assign applied_o    = applied_ff;

endmodule : pnc_top

`default_nettype wire

//--- sim/pnc_drv_model.sv
`timescale 1ns/1ps
`default_nettype none

// power stage seen from the drive pins
module pnc_drv_model (
    input  wire logic       clk_i,
    input  wire logic       drv_high_i,
    input  wire logic       drv_low_i,
    input  wire logic [1:0] mode_i,
    output var  logic [1:0] up_o = 2'h0,
    output var  logic [1:0] dn_o = 2'h0
);
    // shoot-through asks for more gap; mode bit 0 pushes up, bit 1 down, both at once in mode 3
    always @(posedge clk_i) begin
        up_o <= (mode_i[0] || (drv_high_i && drv_low_i)) ? 2'h3 : 2'h0;
        dn_o <= (mode_i[1]) ? 2'h3 : 2'h0;
    end
endmodule : pnc_drv_model
`default_nettype wire

//--- sim/pnc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module pnc_chk
    import pnc_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        cmd_rd_i,
    input wire logic [7:0]  cmd_code_i,
    input wire logic [15:0] cmd_rdata_o,
    input wire logic        cmd_rvalid_o,
    input wire logic        drv_high_o,
    input wire logic        drv_low_o,
    input wire logic [15:0] applied_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // default 16 ns gap is two taps with both drives off
    sequence both_off2;
        (!drv_high_o && !drv_low_o) [*2];
    endsequence
    rd_answer_a: assert property (cmd_rd_i |=> cmd_rvalid_o)
        else $error("read not answered");
    rd_quiet_a: assert property (!cmd_rd_i |=> !cmd_rvalid_o)
        else $error("stray read valid");
    rdata_hold_a: assert property (!cmd_rd_i |=> $stable(cmd_rdata_o))
        else $error("read data moved");
    unk_zero_a: assert property (cmd_rd_i && cmd_code_i != PNC_CMD_DELAY
        && cmd_code_i != PNC_CMD_CONFIG |=> cmd_rdata_o == 16'h0000)
        else $error("unknown code not zero");
    reset_state_a: assert property ($fell(sys_rst_i) |->
        applied_o == PNC_DELAY_RESET && !drv_high_o && !cmd_rvalid_o)
        else $error("bad state after reset");
    no_shoot_a: assert property (applied_o == 16'h1010 &&
        $past(applied_o, 8) == 16'h1010 |-> !(drv_high_o && drv_low_o))
        else $error("drives overlap");
    gap_lh_a: assert property ($fell(drv_low_o) && applied_o == 16'h1010 |-> both_off2)
        else $error("short low to high gap");
    gap_hl_a: assert property ($fell(drv_high_o) && applied_o == 16'h1010 |-> both_off2)
        else $error("short high to low gap");
endmodule : pnc_chk

bind pnc_top pnc_chk i_pnc_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_rd_i(cmd_rd_i),
    .cmd_code_i(cmd_code_i), .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
    .drv_high_o(drv_high_o), .drv_low_o(drv_low_o), .applied_o(applied_o));
`default_nettype wire

//--- sim/pnc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module pnc_top_tb;
    import pnc_pkg::*;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [7:0]  code = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        pwm_i = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic [1:0]  up;
    logic [1:0]  dn;
    logic [15:0] rdata;
    logic [15:0] applied;
    logic        rvalid;
    logic        hi;
    logic        lo;
    int          errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    logic [31:0] seed = 32'h47F3;

    pnc_top i_pnc_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_wr_i(wr_s),
        .cmd_rd_i(rd_s), .cmd_code_i(code), .cmd_wdata_i(wdata), .cmd_rdata_o(rdata),
        .cmd_rvalid_o(rvalid), .pwm_i(pwm_i), .adapt_up_i(up), .adapt_dn_i(dn),
        .drv_high_o(hi), .drv_low_o(lo), .applied_o(applied));
    pnc_drv_model i_pnc_drv_model (.clk_i(clk_i), .drv_high_i(hi), .drv_low_i(lo),
        .mode_i(mode), .up_o(up), .dn_o(dn));

    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // hang guard, far above the roughly 670 cycles the run needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            results();
        end
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // clamped ns to tap count, rounding up at 10 ns
    function automatic int tap(input logic signed [7:0] ns);
        int v;
        v = (ns > PNC_MAX_NS) ? PNC_MAX_NS : (ns < PNC_MIN_NS) ? PNC_MIN_NS : ns;
        return (v + 29) / 10;
    endfunction : tap

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one write, then an idle edge so the strobe never toggles twice at once
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        wr_s <= 1'b1;
        code <= c;
        wdata <= d;
        @(posedge clk_i);
        wr_s <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [15:0] exp, input string what);
        rd_s <= 1'b1;
        code <= c;
        @(posedge clk_i);
        rd_s <= 1'b0;
        #1;
        check(what, rdata, exp);
        check("rvalid", {15'h0000, rvalid}, 16'h0001);
        @(posedge clk_i);
    endtask : rd
    // cycles from a pwm edge until the old drive drops and the new one rises
    task automatic edge_chk(input logic lvl, input int t_on, input string what);
        int n_off;
        int n_on;
        pwm_i <= lvl;
        n_off = 0;
        n_on = 0;
        for (int n = 1; n < 20; n++) begin
            @(posedge clk_i);
            #1;
            if (n_off == 0 && (lvl ? !lo : !hi)) n_off = n;
            if (n_on == 0 && (lvl ? hi : lo)) n_on = n;
        end
        // return on an edge so the next stimulus lands on one
        @(posedge clk_i);
        // base tap 2 plus history and drive registers
        check({what, " off"}, 16'(n_off), 16'h0004);
        check(what, 16'(n_on), 16'(t_on + 2));
    endtask : edge_chk

    initial begin
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        rd(PNC_CMD_DELAY, PNC_DELAY_RESET, "delay");
        rd(PNC_CMD_CONFIG, PNC_CONFIG_RESET, "config");
        rd(8'hDF, 16'h0000, "unmapped");
        // a write to an unknown code must leave the settings alone
        wr(8'hDF, 16'hFFFF);
        rd(PNC_CMD_DELAY, PNC_DELAY_RESET, "delay");
        check("applied", applied, 16'h1010);
        repeat (20) @(posedge clk_i);
        edge_chk(1'b1, 4, "rise");
        edge_chk(1'b0, 4, "fall");
        // clamp and overlap corners first, then random frozen settings
        for (int i = 0; i < 10; i++) begin
            logic [15:0] d;
            d = (i == 0) ? 16'h50F1 : (i == 1) ? 16'hF13C
                : {8'(rnd() % 76 - 15), 8'(rnd() % 76 - 15)};
            wr(PNC_CMD_DELAY, d);
            rd(PNC_CMD_DELAY, d, "delay");
            check("applied", applied, d);
            edge_chk(1'b1, tap(d[7:0]), "rise");
            edge_chk(1'b0, tap(d[15:8]), "fall");
        end
        // a read between the paired writes must not break the pair
        wr(PNC_CMD_DELAY, 16'h141E);
        rd(PNC_CMD_DELAY, 16'h141E, "delay");
        wr(PNC_CMD_CONFIG, 16'h0A06);
        mode <= 2'h1;
        repeat (40) @(posedge clk_i);
        check("adapt max", applied, 16'h141E);
        mode <= 2'h2;
        repeat (40) @(posedge clk_i);
        check("adapt min", applied, 16'h0A06);
        wr(PNC_CMD_CONFIG, 16'h8A06);
        repeat (4) @(posedge clk_i);
        check("hl frozen", applied, 16'h1406);
        wr(PNC_CMD_CONFIG, 16'h0A86);
        repeat (40) @(posedge clk_i);
        check("lh frozen", applied, 16'h0A1E);
        // up and down together must hold the adaptive edge where it is
        mode <= 2'h3;
        repeat (10) @(posedge clk_i);
        check("adapt hold", applied, 16'h0A1E);
        mode <= 2'h0;
        results();
    end

    task automatic results();
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
endmodule : pnc_top_tb
`default_nettype wire
